// ===== src/mmsave_map.svh
/*
  Named offsets, field positions, reset values and encodings for the
  management-mode save slot logic.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef MMSAVE_MAP_SVH
`define MMSAVE_MAP_SVH
// ==========================================================================
// Slot offsets within the save area
// ==========================================================================
`define MMS_OFS_BASE_SLOT     16'h7EF8
`define MMS_OFS_IO_RESTART    16'h7F00
`define MMS_OFS_HALT_RESTART  16'h7F02
`define MMS_OFS_REVISION      16'h7EFC
`define MMS_OFS_IO_TRAP       16'h7FA4
// ==========================================================================
// Values and fields
// ==========================================================================
`define MMS_BASE_RESET        32'h0003_0000
`define MMS_VECTOR_OFS        32'h0000_8000
`define MMS_ALIGN_MASK        32'h0000_7FFF
`define MMS_IO_RESTART_YES    16'h00FF
`define MMS_IO_RESTART_NO     16'h0000
// Revision level field; the value is arbitrary and names no maker or part.
`define MMS_REV_LEVEL         16'h0A5C
`define MMS_REV_RELOC_BIT     17
`define MMS_REV_TRAP_BIT      16
`define MMS_TRAP_ADDR_LSB     16
`define MMS_TRAP_VALID_BIT    1
`define MMS_TRAP_READ_BIT     0
`endif

// ===== src/mmsave_pkg.sv
/*
  Types shared by both ends of the management-mode save slot logic.
  Assumes the map header is available on the include path.
*/
`default_nettype none
package mmsave_pkg;
  // Processor end state machine.
  typedef enum logic [2:0] {
    MMS_RUN, MMS_HALTED, MMS_IN_MGMT, MMS_IO_REDO, MMS_HALT_FETCH, MMS_SHUTDOWN
  } mmsave_state_t;
  // Chipset end state machine.
  typedef enum logic [1:0] {
    MMS_C_IDLE, MMS_C_WAIT, MMS_C_ACTIVE
  } mmsave_cstate_t;
endpackage : mmsave_pkg
`default_nettype wire

// ===== src/mmsave_if.sv
/*
  Interface joining the processor end and the chipset end.
  Assumes one clock drives both ends.
*/
`default_nettype none
interface mmsave_if;
  logic        mgmt_interrupt_request; // Chipset asks for management mode.
  logic        mgmt_mode_active;       // Processor is in management mode.
  logic        io_cycle;               // Processor performs an I/O access.
  logic [15:0] io_addr;                // Address of that access.
  logic        io_read;                // 1 read, 0 write.
  logic        io_valid_instr;         // Access came from an I/O instruction.
  modport cpu (output mgmt_mode_active, io_cycle, io_addr, io_read, io_valid_instr,
               input mgmt_interrupt_request);
  modport chipset (input mgmt_mode_active, io_cycle, io_addr, io_read, io_valid_instr,
                   output mgmt_interrupt_request);
endinterface : mmsave_if
`default_nettype wire

// ===== src/mmsave_chipset.sv
/*
  Chipset end: raises a management interrupt for a trapped I/O access or
  on software demand, and holds it until the processor acknowledges.
  Assumes the processor end drives the link on the same clock.
*/
`include "mmsave_map.svh"
`default_nettype none
module mmsave_chipset
  import mmsave_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  mmsave_if.chipset        lnk,
  input  wire logic        trap_enable,
  input  wire logic [15:0] trap_addr,
  input  wire logic        soft_request,
  output logic             request_busy
);
  typedef struct packed {
    mmsave_cstate_t st;
    logic           req;
  } mmsave_cs_t;
  mmsave_cs_t s_q, s_d;

  // ========================================================================
  // Request sequencing
  // ========================================================================
  // Request is raised on the first trapped access so a repeated string
  // access stops right there, and held until the processor enters.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      MMS_C_IDLE: begin
        if ((trap_enable && lnk.io_cycle && lnk.io_addr == trap_addr) || soft_request) begin
          s_d.st  = MMS_C_WAIT;
          s_d.req = 1'b1;
        end
      end
      MMS_C_WAIT: begin
        if (lnk.mgmt_mode_active) begin
          s_d.st  = MMS_C_ACTIVE;
          s_d.req = 1'b0;
        end
      end
      MMS_C_ACTIVE: begin
        if (!lnk.mgmt_mode_active) begin
          s_d.st = MMS_C_IDLE;
        end
      end
      default: begin
        s_d.st  = MMS_C_IDLE;
        s_d.req = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: MMS_C_IDLE, req: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Request and busy flag come straight from the state register.
  assign lnk.mgmt_interrupt_request = s_q.req;
  assign request_busy               = (s_q.st != MMS_C_IDLE);
endmodule // mmsave_chipset
`default_nettype wire

// ===== src/mmsave_cpu.sv
/*
  Processor end: save-area slots written at management-mode entry and
  interpreted at the resume instruction, plus base relocation.
  Assumes the core reports halt, I/O and resume events as one-cycle pulses
  and that the handler reaches slots through the slot port.
*/
`include "mmsave_map.svh"
`default_nettype none
module mmsave_cpu
  import mmsave_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  mmsave_if.cpu            lnk,
  input  wire logic        core_halt,
  input  wire logic        core_io,
  input  wire logic [15:0] core_io_addr,
  input  wire logic        core_io_read,
  input  wire logic        core_io_valid,
  input  wire logic        core_resume,
  input  wire logic        fetch_done,
  input  wire logic        slot_wr,
  input  wire logic [15:0] slot_addr,
  input  wire logic [31:0] slot_wdata,
  output logic [31:0]      slot_rdata,
  output logic [31:0]      mgmt_base,
  output logic [31:0]      jump_vector,
  output logic             enter_pulse,
  output logic             io_redo,
  output logic             halt_fetch_req,
  output logic             halt_bus_cycle,
  output logic             cpu_halted,
  output logic             cpu_shutdown
);
  typedef struct packed {
    mmsave_state_t st;
    logic [31:0]   base;
    logic [31:0]   base_slot;
    logic [15:0]   io_restart;
    logic [15:0]   halt_restart;
    logic [31:0]   trap_word;
    logic [31:0]   rev_word;
    logic          rev_seen;
    logic [31:0]   rdata;
    logic          enter;
    logic          redo;
    logic          hcycle;
    logic          io_pend;
    logic [15:0]   io_a;
    logic          io_r;
    logic          io_v;
    logic          io_out;
  } mmsave_s_t;
  mmsave_s_t s_q, s_d;

  localparam logic [31:0] REV_FIXED = (32'h1 << `MMS_REV_RELOC_BIT) |
                                      (32'h1 << `MMS_REV_TRAP_BIT) |
                                      {16'h0000, `MMS_REV_LEVEL};

  // ========================================================================
  // Entry, handler slot access and resume
  // ========================================================================
  // All slot traffic is folded into one process; a handler write is taken in management mode only, so none meets entry,
  // and one landing with resume still lands while resume acts on the slot values from before it.
  always_comb begin
    s_d        = s_q;
    s_d.enter  = 1'b0;
    s_d.redo   = 1'b0;
    s_d.hcycle = 1'b0;
    s_d.io_out = 1'b0;
    // Core I/O access is shown to the chipset and remembered for trapping.
    if (core_io && s_q.st == MMS_RUN) begin
      s_d.io_out  = 1'b1;
      s_d.io_pend = 1'b1;
      s_d.io_a    = core_io_addr;
      s_d.io_r    = core_io_read;
      s_d.io_v    = core_io_valid;
    end
    if (core_halt && s_q.st == MMS_RUN) begin
      s_d.st = MMS_HALTED;
    end
    // Handler slot reads answer the next cycle.
    case (slot_addr)
      `MMS_OFS_BASE_SLOT:    s_d.rdata = s_q.base_slot;
      `MMS_OFS_IO_RESTART:   s_d.rdata = {16'h0000, s_q.io_restart};
      `MMS_OFS_HALT_RESTART: s_d.rdata = {16'h0000, s_q.halt_restart};
      `MMS_OFS_REVISION:     s_d.rdata = s_q.rev_word;
      `MMS_OFS_IO_TRAP:      s_d.rdata = s_q.trap_word;
      default:               s_d.rdata = 32'h0000_0000;
    endcase
    if (slot_wr && s_q.st == MMS_IN_MGMT) begin
      case (slot_addr)
        `MMS_OFS_BASE_SLOT:    s_d.base_slot    = slot_wdata;
        `MMS_OFS_IO_RESTART:   s_d.io_restart   = slot_wdata[15:0];
        `MMS_OFS_HALT_RESTART: s_d.halt_restart = slot_wdata[15:0];
        default: begin
        end
      endcase
    end
    case (s_q.st)
      MMS_RUN, MMS_HALTED: begin
        if (lnk.mgmt_interrupt_request) begin
          s_d.st    = MMS_IN_MGMT;
          s_d.enter = 1'b1;
          s_d.halt_restart = {15'h0000, s_q.st == MMS_HALTED || core_halt};
          s_d.io_restart = `MMS_IO_RESTART_NO;
          s_d.base_slot = s_q.base;
          s_d.rev_word = REV_FIXED;
          s_d.trap_word = {s_q.io_a, 14'h0000, s_q.io_v & s_q.io_pend, s_q.io_r};
          // An access landing in the entry cycle stays pending, so the set wins.
          s_d.io_pend   = s_d.io_out;
        end
      end
      MMS_IN_MGMT: begin
        if (core_resume) begin
          s_d.rev_seen = (s_q.rev_word == REV_FIXED);
          if ((s_q.base_slot & `MMS_ALIGN_MASK) != 32'h0000_0000) begin
            s_d.st = MMS_SHUTDOWN;
          end else begin
            s_d.base = s_q.base_slot;
            if (s_q.io_restart == `MMS_IO_RESTART_YES) begin
              s_d.st   = MMS_IO_REDO;
              s_d.redo = 1'b1;
            end else if (s_q.halt_restart[0]) begin
              s_d.st = MMS_HALT_FETCH;
            end else begin
              s_d.st = MMS_RUN;
            end
          end
        end
      end
      MMS_IO_REDO: begin
        s_d.st = MMS_RUN;
      end
      MMS_HALT_FETCH: begin
        if (fetch_done) begin
          s_d.st     = MMS_HALTED;
          s_d.hcycle = 1'b1;
        end
      end
      MMS_SHUTDOWN: begin
      end
      default: begin
        s_d.st = MMS_RUN;
      end
    endcase
  end

  // State register; hard reset restores the default base.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q           <= '0;
      s_q.st        <= MMS_RUN;
      s_q.base      <= `MMS_BASE_RESET;
      s_q.base_slot <= `MMS_BASE_RESET;
      s_q.rev_word  <= REV_FIXED;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // vector offset
  assign jump_vector        = s_q.base + `MMS_VECTOR_OFS;
  assign mgmt_base          = s_q.base;
  assign slot_rdata         = s_q.rdata;
  assign enter_pulse        = s_q.enter;
  assign io_redo            = s_q.redo;
  assign halt_fetch_req     = (s_q.st == MMS_HALT_FETCH);
  assign halt_bus_cycle     = s_q.hcycle;
  assign cpu_halted         = (s_q.st == MMS_HALTED);
  assign cpu_shutdown       = (s_q.st == MMS_SHUTDOWN);
  assign lnk.mgmt_mode_active = (s_q.st == MMS_IN_MGMT);
  assign lnk.io_cycle       = s_q.io_out;
  assign lnk.io_addr        = s_q.io_a;
  assign lnk.io_read        = s_q.io_r;
  assign lnk.io_valid_instr = s_q.io_v;
endmodule // mmsave_cpu
`default_nettype wire

// ===== test/mmsave_monitor.sv
/*
  Checker for the link between the processor end and the chipset end.
  Assumes it is instantiated beside the interface, on the design clock.
*/
`default_nettype none
module mmsave_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        mgmt_interrupt_request,
  input wire logic        mgmt_mode_active,
  input wire logic        io_cycle,
  input wire logic [15:0] io_addr,
  input wire logic        io_read,
  input wire logic        io_valid_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Link handshake
  // ========================================================================
  // One clock domain, so every property shares these defaults.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A fresh request outside management mode is answered one cycle later.
  entry_answer_a: assert property ($rose(mgmt_interrupt_request) && !mgmt_mode_active
    |=> mgmt_mode_active) else $error("request not answered by entry");
  // The chipset lets go the cycle after it sees the processor enter.
  request_drop_a: assert property ($rose(mgmt_mode_active)
    |=> !mgmt_interrupt_request) else $error("request held after entry");
  // An unanswered request must not vanish before entry.
  request_hold_a: assert property (mgmt_interrupt_request && !mgmt_mode_active
    |=> mgmt_interrupt_request) else $error("request withdrawn early");
  // Entry stands for more than one cycle before any resume can land.
  mode_hold_a: assert property ($rose(mgmt_mode_active)
    |=> mgmt_mode_active) else $error("management mode dropped at once");
  // A second request is never raised while a session is still running.
  mgmt_quiet_a: assert property (mgmt_mode_active && $past(mgmt_mode_active)
    |-> !mgmt_interrupt_request) else $error("request raised inside session");
  // Leaving a session must not coincide with a fresh request.
  exit_quiet_a: assert property ($fell(mgmt_mode_active)
    |-> !mgmt_interrupt_request) else $error("request present at session exit");

  // Main scenarios seen.
  cover property ($rose(mgmt_mode_active));
  cover property (io_cycle && io_read && io_valid_instr && io_addr != 16'h0000);
  cover property ($fell(mgmt_mode_active));
endmodule // mmsave_monitor
`default_nettype wire

// ===== test/tb_mgmt_mode_save_slot_logic.sv
/*
  Self-checking bench joining both ends through the interface.
  Assumes package, interface, map header and design files compile first.
*/
`include "mmsave_map.svh"
`default_nettype none
module tb_mgmt_mode_save_slot_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Stimulus and observed signals
  // ========================================================================
  logic clk = 1'b0, rst_b = 1'b0, trap_enable = 1'b1, soft_request = 1'b0;
  logic core_halt = 1'b0, core_io = 1'b0, core_io_read = 1'b1, core_io_valid = 1'b1;
  logic core_resume = 1'b0, fetch_done = 1'b0, slot_wr = 1'b0, request_busy;
  logic [15:0] trap_addr = 16'h0ABC, core_io_addr = 16'h0ABC, slot_addr = 16'h0000;
  logic [31:0] slot_wdata = 32'h0, slot_rdata, mgmt_base, jump_vector;
  logic enter_pulse, io_redo, halt_fetch_req, halt_bus_cycle, cpu_halted, cpu_shutdown;
  logic [6:0] sg;
  int n_mismatch = 0;
  int comparisons = 0;
  mmsave_if lnk ();
  // Flags that bounded waits look at, by index.
  assign sg = {cpu_shutdown, cpu_halted, halt_bus_cycle, io_redo, halt_fetch_req,
               ~lnk.mgmt_mode_active, lnk.mgmt_mode_active};
  always #5 clk = ~clk;
  mmsave_cpu mmsave_cpu_i (.clk, .rst_b, .lnk(lnk.cpu), .core_halt, .core_io, .core_io_addr,
    .core_io_read, .core_io_valid, .core_resume, .fetch_done, .slot_wr, .slot_addr,
    .slot_wdata, .slot_rdata, .mgmt_base, .jump_vector, .enter_pulse, .io_redo,
    .halt_fetch_req, .halt_bus_cycle, .cpu_halted, .cpu_shutdown);
  mmsave_chipset mmsave_chipset_i (.clk, .rst_b, .lnk(lnk.chipset), .trap_enable,
    .trap_addr, .soft_request, .request_busy);
  mmsave_monitor mmsave_monitor_i (.clk, .rst_b,
    .mgmt_interrupt_request(lnk.mgmt_interrupt_request),
    .mgmt_mode_active(lnk.mgmt_mode_active), .io_cycle(lnk.io_cycle),
    .io_addr(lnk.io_addr), .io_read(lnk.io_read), .io_valid_instr(lnk.io_valid_instr));
  // ========================================================================
  // Access tasks
  // ========================================================================
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read data lags the address by one edge, so it is compared a cycle later.
  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    slot_addr = a;
    @(negedge clk);
    cmp(slot_rdata & m, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    slot_wr = 1'b1;
    slot_addr = a;
    slot_wdata = d;
    @(negedge clk);
    slot_wr = 1'b0;
    // Let an edge pass so a following write never re-raises the strobe at once.
    @(negedge clk);
  endtask
  // Bounded wait; running out is a mismatch and ends the run.
  task automatic wt(input int s);
    int n;
    n = 0;
    while (sg[s] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (sg[s] !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic enter();
    soft_request = 1'b1;
    @(negedge clk);
    soft_request = 1'b0;
    wt(0);
  endtask
  task automatic resume();
    core_resume = 1'b1;
    @(negedge clk);
    core_resume = 1'b0;
  endtask
  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    cmp(mgmt_base, `MMS_BASE_RESET);
    cmp(jump_vector, 32'h0003_8000);
    // Trapped read, then I/O restart and relocation on resume.
    core_io = 1'b1;
    @(negedge clk);
    core_io = 1'b0;
    wt(0);
    cmp(32'(enter_pulse), 32'h1);
    cmp(32'(request_busy), 32'h1);
    rd(`MMS_OFS_IO_TRAP, '1, 32'h0ABC_0003);
    rd(`MMS_OFS_IO_RESTART, '1, 32'h0);
    rd(`MMS_OFS_HALT_RESTART, '1, 32'h0);
    rd(`MMS_OFS_BASE_SLOT, '1, 32'h0003_0000);
    rd(`MMS_OFS_REVISION, '1, {16'h0003, `MMS_REV_LEVEL});
    wr(`MMS_OFS_IO_RESTART, 32'h0000_00FF);
    wr(`MMS_OFS_BASE_SLOT, 32'h0004_8000);
    trap_enable = 1'b0;
    resume();
    wt(3);
    cmp(mgmt_base, 32'h0004_8000);
    cmp(jump_vector, 32'h0005_0000);
    $display("test trap restart done");
    // Halt entry, resumed once onward and once back into halt.
    for (int b = 0; b < 2; b++) begin
      // One idle cycle lets the core return to run before the halt.
      @(negedge clk);
      core_halt = 1'b1;
      @(negedge clk);
      core_halt = 1'b0;
      enter();
      rd(`MMS_OFS_HALT_RESTART, '1, 32'h1);
      rd(`MMS_OFS_IO_TRAP, 32'h2, 32'h0);
      rd(`MMS_OFS_BASE_SLOT, '1, 32'h0004_8000);
      wr(`MMS_OFS_HALT_RESTART, 32'(b));
      resume();
      wt(1);
      @(negedge clk);
      cmp(32'(halt_fetch_req), 32'(b));
      if (b == 1) begin
        fetch_done = 1'b1;
        @(negedge clk);
        fetch_done = 1'b0;
        wt(4);
        wt(5);
      end else begin
        cmp(32'(cpu_halted), 32'h0);
      end
      $display("test halt restart %0d done", b);
    end
    // Unaligned base at resume leaves the base alone and shuts down.
    enter();
    wr(`MMS_OFS_BASE_SLOT, 32'h0005_0100);
    resume();
    wt(6);
    cmp(mgmt_base, 32'h0004_8000);
    $display("test unaligned base done");
    // A hard reset in mid-run leaves shutdown and restores the default base.
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    cmp(mgmt_base, `MMS_BASE_RESET);
    cmp(32'(cpu_shutdown), 32'h0);
    cmp(32'(request_busy), 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule // tb_mgmt_mode_save_slot_logic
`default_nettype wire
